// File: hw/uie_mask_regs.sv
// interrupt enable mask registers of the full-speed host function
// assumes a decoded memory target delivers at most one access per clk_i;
// event flags are held by the status register outside this block

`timescale 1ns/1ps

module uie_mask_regs
  import uie_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        soft_rst_i,
  input  wire uie_req_s    reg_req_i,
  output uie_rsp_s         reg_rsp_o,
  input  wire logic [31:0] irq_event_flags_i,
  output logic             irq_req_o,
  output logic [31:0]      irq_pending_o,
  output logic [31:0]      mask_value_o,
  output logic             rsv_write_o
);

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  uie_sel_e    acc_sel;
  logic        acc_wr;
  logic        acc_rd;
  logic        acc_mapped;
  logic [31:0] lane_mask;
  logic [31:0] wr_bits;

  always_comb begin
    acc_sel    = uie_decode(reg_req_i.addr);
    acc_mapped = (acc_sel != UIE_SEL_NONE);
    // a combined read/write is taken as a write
    acc_wr     = reg_req_i.wr;
    acc_rd     = reg_req_i.rd & ~reg_req_i.wr;
    lane_mask  = uie_be_mask(reg_req_i.be);
    wr_bits    = reg_req_i.wdata & lane_mask;
  end

  // ---------------------------------------------------------------
  // set and clear masks
  // ---------------------------------------------------------------
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic [31:0] rsv_bits;

  always_comb begin
    set_bits = 32'h0000_0000;
    clr_bits = 32'h0000_0000;
    rsv_bits = wr_bits & ~UIE_IMPL_MASK;
    if (acc_wr) begin
      case (acc_sel)
        UIE_SEL_SET: begin
          set_bits = wr_bits & UIE_IMPL_MASK;
        end
        UIE_SEL_CLEAR: begin
          clr_bits = wr_bits & UIE_IMPL_MASK;
        end
        default: begin
          set_bits = 32'h0000_0000;
          clr_bits = 32'h0000_0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // enable register
  // ---------------------------------------------------------------
  logic [31:0] mask_d;
  logic [31:0] mask_q;

  always_comb begin
    mask_d = mask_q | set_bits;
    mask_d = mask_d & ~clr_bits;
    mask_d = mask_d & UIE_IMPL_MASK;
    if (soft_rst_i) begin
      mask_d = UIE_MASK_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask_q <= UIE_MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ---------------------------------------------------------------
  // read path and answer
  // ---------------------------------------------------------------
  // every access is answered one cycle later, mapped or not, so a
  // stray address never leaves the target waiting
  uie_rsp_s rsp_d;
  uie_rsp_s rsp_q;

  always_comb begin
    rsp_d.ack   = acc_wr | acc_rd;
    rsp_d.rdata = UIE_RDATA_IDLE;
    if (acc_rd) begin
      case (acc_sel)
        UIE_SEL_SET: begin
          rsp_d.rdata = mask_q & lane_mask;
        end
        UIE_SEL_CLEAR: begin
          rsp_d.rdata = mask_q & lane_mask;
        end
        default: begin
          rsp_d.rdata = UIE_RDATA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // ---------------------------------------------------------------
  // diagnostics
  // ---------------------------------------------------------------
  // reserved ones are not stored; a pulse flags the driver bug
  logic rsv_wr_d;
  logic rsv_wr_q;

  always_comb begin
    rsv_wr_d = acc_wr & acc_mapped & (|rsv_bits);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rsv_wr_q <= 1'b0;
    end else begin
      rsv_wr_q <= rsv_wr_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupt gate
  // ---------------------------------------------------------------
  // the gate sees the stored mask, so a write takes effect on the
  // request one cycle after the register updates
  logic        gate_irq;
  logic [31:0] gate_pending;

  uie_irq_gate u_gate (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .soft_rst_i (soft_rst_i),
    .mask_i     (mask_q),
    .flags_i    (irq_event_flags_i),
    .irq_o      (gate_irq),
    .pending_o  (gate_pending)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rsp_o     = rsp_q;
  assign irq_req_o     = gate_irq;
  assign irq_pending_o = gate_pending;
  assign mask_value_o  = mask_q;
  assign rsv_write_o   = rsv_wr_q;

endmodule

// File: hw/uie_pkg.sv
// constants, carriers and helpers for the usb host interrupt enable/mask block
// assumes a decoded memory-space target feeding one access per clock

package uie_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned UIE_ADDR_W          = 8;
  localparam int unsigned UIE_DATA_W          = 32;
  localparam logic [7:0]  UIE_OFS_MASK_SET    = 8'h10;
  localparam logic [7:0]  UIE_OFS_MASK_CLEAR  = 8'h14;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned UIE_BIT_MASTER      = 31;
  localparam int unsigned UIE_BIT_OWNERSHIP   = 30;
  localparam int unsigned UIE_BIT_ROOT_PORT   = 6;
  localparam int unsigned UIE_BIT_FRAME_WRAP  = 5;
  localparam int unsigned UIE_BIT_FATAL       = 4;
  localparam int unsigned UIE_BIT_WAKEUP      = 3;
  localparam int unsigned UIE_BIT_FRAME_START = 2;
  localparam int unsigned UIE_BIT_DONE_QUEUE  = 1;
  localparam int unsigned UIE_BIT_OVERRUN     = 0;

  // implemented bits; 29..7 are reserved
  localparam logic [31:0] UIE_IMPL_MASK       = 32'hc000_007f;
  localparam logic [31:0] UIE_EVENT_MASK      = 32'h4000_007f;
  localparam logic [31:0] UIE_MASK_RESET      = 32'h0000_0000;
  localparam logic [31:0] UIE_RDATA_IDLE      = 32'h0000_0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } uie_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } uie_rsp_s;

  typedef enum logic [1:0] {
    UIE_SEL_NONE,
    UIE_SEL_SET,
    UIE_SEL_CLEAR
  } uie_sel_e;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic uie_sel_e uie_decode(input logic [7:0] addr);
    if (addr == UIE_OFS_MASK_SET) begin
      return UIE_SEL_SET;
    end else if (addr == UIE_OFS_MASK_CLEAR) begin
      return UIE_SEL_CLEAR;
    end
    return UIE_SEL_NONE;
  endfunction

  function automatic logic [31:0] uie_be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

endpackage

// File: hw/uie_irq_gate.sv
// gates latched event flags with the enable mask onto one interrupt request
// assumes flags come from the status register, already in the clk_i domain

`timescale 1ns/1ps

module uie_irq_gate
  import uie_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        soft_rst_i,
  input  wire logic [31:0] mask_i,
  input  wire logic [31:0] flags_i,
  output logic             irq_o,
  output logic [31:0]      pending_o
);

  // ---------------------------------------------------------------
  // per-event contribution
  // ---------------------------------------------------------------
  logic [31:0] contrib;
  logic        master_on;
  logic        irq_d;
  logic        irq_q;
  logic [31:0] pending_d;
  logic [31:0] pending_q;

  always_comb begin
    contrib = 32'h0000_0000;
    contrib[UIE_BIT_OWNERSHIP] = flags_i[UIE_BIT_OWNERSHIP] & mask_i[UIE_BIT_OWNERSHIP];
    contrib[UIE_BIT_ROOT_PORT] = flags_i[UIE_BIT_ROOT_PORT] & mask_i[UIE_BIT_ROOT_PORT];
    contrib[UIE_BIT_FRAME_WRAP] = flags_i[UIE_BIT_FRAME_WRAP] & mask_i[UIE_BIT_FRAME_WRAP];
    contrib[UIE_BIT_FATAL] = flags_i[UIE_BIT_FATAL] & mask_i[UIE_BIT_FATAL];
    contrib[UIE_BIT_WAKEUP] = flags_i[UIE_BIT_WAKEUP] & mask_i[UIE_BIT_WAKEUP];
    contrib[UIE_BIT_FRAME_START] = flags_i[UIE_BIT_FRAME_START] & mask_i[UIE_BIT_FRAME_START];
    contrib[UIE_BIT_DONE_QUEUE] = flags_i[UIE_BIT_DONE_QUEUE] & mask_i[UIE_BIT_DONE_QUEUE];
    contrib[UIE_BIT_OVERRUN] = flags_i[UIE_BIT_OVERRUN] & mask_i[UIE_BIT_OVERRUN];
  end

  assign master_on = mask_i[UIE_BIT_MASTER];

  always_comb begin
    pending_d = contrib;
    irq_d     = master_on & (|contrib);
    if (soft_rst_i) begin
      pending_d = 32'h0000_0000;
      irq_d     = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_q     <= 1'b0;
      pending_q <= 32'h0000_0000;
    end else begin
      irq_q     <= irq_d;
      pending_q <= pending_d;
    end
  end

  assign irq_o     = irq_q;
  assign pending_o = pending_q;

endmodule

// File: dv/uie_mask_assertions.sv
// concurrent checks on the interrupt enable mask register ports
// assumes one clk_i domain; bound onto uie_mask_regs below
`timescale 1ns/1ps

module uie_mask_assertions
  import uie_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        soft_rst_i,
  input  wire uie_req_s    reg_req_i,
  input  wire uie_rsp_s    reg_rsp_o,
  input  wire logic [31:0] irq_event_flags_i,
  input  wire logic        irq_req_o,
  input  wire logic [31:0] irq_pending_o,
  input  wire logic [31:0] mask_value_o,
  input  wire logic        rsv_write_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // full-word writes only, so byte lanes need not be modelled here
  logic        full_wr;
  logic [31:0] hits;
  assign full_wr = reg_req_i.wr && reg_req_i.be == 4'hf && !soft_rst_i;
  assign hits    = irq_event_flags_i & mask_value_o & UIE_EVENT_MASK;

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  ack_latency_a: assert property (
    (reg_req_i.wr || reg_req_i.rd) |=> reg_rsp_o.ack) else $error("ack missing");
  rsv_pulse_a: assert property (
    full_wr && reg_req_i.addr == UIE_OFS_MASK_SET && (reg_req_i.wdata & ~UIE_IMPL_MASK) != 32'h0
    |=> rsv_write_o) else $error("reserved write not flagged");
  irq_gate_a: assert property (
    !soft_rst_i |=> irq_req_o == $past(mask_value_o[31] && (hits != 32'h0)))
    else $error("irq request wrong");
  pending_map_a: assert property (
    !soft_rst_i |=> irq_pending_o == $past(hits)) else $error("pending wrong");
  set_write_a: assert property (
    full_wr && reg_req_i.addr == UIE_OFS_MASK_SET |=> mask_value_o ==
    ($past(mask_value_o) | ($past(reg_req_i.wdata) & UIE_IMPL_MASK))) else $error("set wrong");
  clear_write_a: assert property (
    full_wr && reg_req_i.addr == UIE_OFS_MASK_CLEAR |=> mask_value_o ==
    ($past(mask_value_o) & ~$past(reg_req_i.wdata))) else $error("clear wrong");
  clear_read_a: assert property (
    reg_req_i.rd && !reg_req_i.wr && reg_req_i.be == 4'hf &&
    reg_req_i.addr == UIE_OFS_MASK_CLEAR |=> reg_rsp_o.rdata == $past(mask_value_o))
    else $error("clear readback wrong");
  mask_hold_a: assert property (
    !soft_rst_i && !(reg_req_i.wr && (reg_req_i.addr == UIE_OFS_MASK_SET ||
    reg_req_i.addr == UIE_OFS_MASK_CLEAR)) |=> $stable(mask_value_o)) else $error("mask moved");
  soft_clear_a: assert property (
    soft_rst_i |=> mask_value_o == UIE_MASK_RESET && !irq_req_o) else $error("soft reset");
  reserved_zero_a: assert property (
    (mask_value_o & ~UIE_IMPL_MASK) == 32'h0) else $error("reserved bit stored");
endmodule

bind uie_mask_regs uie_mask_assertions uie_mask_assertions_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .soft_rst_i(soft_rst_i), .reg_req_i(reg_req_i),
  .reg_rsp_o(reg_rsp_o), .irq_event_flags_i(irq_event_flags_i), .irq_req_o(irq_req_o),
  .irq_pending_o(irq_pending_o), .mask_value_o(mask_value_o), .rsv_write_o(rsv_write_o));

// File: dv/tb_top.sv
// register-level regression of the interrupt enable mask block
// assumes uie_pkg and the bound checker are compiled first
`timescale 1ns/1ps

module tb_top
  import uie_pkg::*;
;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        soft_rst_i = 1'b0;
  uie_req_s    req     = '0;
  uie_rsp_s    rsp;
  logic [31:0] flags   = '0;
  logic [31:0] pend;
  logic [31:0] mask;
  logic [31:0] got;
  logic [31:0] e;
  logic        irq;
  logic        rsv;
  int          n_fail  = 0;
  int          checks_done = 0;
  int          bits[8] = '{30, 6, 5, 4, 3, 2, 1, 0};

  always #10 clk_i = ~clk_i;

  uie_mask_regs uie_mask_regs_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .soft_rst_i(soft_rst_i), .reg_req_i(req),
    .reg_rsp_o(rsp), .irq_event_flags_i(flags), .irq_req_o(irq), .irq_pending_o(pend),
    .mask_value_o(mask), .rsv_write_o(rsv));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  // one access; wr=0 means read; rdata lands in got
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    @(posedge clk_i);
    req <= '{wr: w, rd: !w, addr: a, be: be, wdata: d};
    @(posedge clk_i);
    req <= '0;
    #1;
    chk("ack", 32'h1, {31'h0, rsp.ack});
    got = rsp.rdata;
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("mask after reset", UIE_MASK_RESET, mask);
    acc(1'b0, UIE_OFS_MASK_SET, 4'hf, 32'h0);
    chk("set read after reset", 32'h0, got);
    @(posedge clk_i);
    flags <= UIE_EVENT_MASK;
    for (int i = 0; i < 8; i++) begin
      e = 32'h1 << bits[i];
      acc(1'b1, UIE_OFS_MASK_SET, 4'hf, 32'h8000_0000 | e);
      tick();
      chk("irq one event", 32'h1, {31'h0, irq});
      chk("pending one event", e, pend);
      acc(1'b1, UIE_OFS_MASK_CLEAR, 4'hf, e);
      chk("mask after clear", 32'h8000_0000, mask);
      tick();
      chk("irq after clear", 32'h0, {31'h0, irq});
    end
    acc(1'b1, UIE_OFS_MASK_SET, 4'hf, UIE_EVENT_MASK);
    acc(1'b1, UIE_OFS_MASK_SET, 4'hf, 32'h0);
    chk("set zero write", 32'hc000_007f, mask);
    acc(1'b1, UIE_OFS_MASK_CLEAR, 4'hf, 32'h0);
    chk("clear zero write", 32'hc000_007f, mask);
    acc(1'b0, UIE_OFS_MASK_CLEAR, 4'hf, 32'h0);
    chk("clear readback", 32'hc000_007f, got);
    acc(1'b1, UIE_OFS_MASK_CLEAR, 4'hf, 32'h8000_0000);
    tick();
    chk("irq master off", 32'h0, {31'h0, irq});
    chk("pending master off", UIE_EVENT_MASK, pend);
    // reserved ones must be dropped, not stored
    acc(1'b1, UIE_OFS_MASK_SET, 4'hf, 32'hffff_ffff);
    chk("rsv pulse", 32'h1, {31'h0, rsv});
    acc(1'b0, UIE_OFS_MASK_SET, 4'hf, 32'h0);
    chk("set readback", UIE_IMPL_MASK, got);
    acc(1'b1, UIE_OFS_MASK_CLEAR, 4'hf, 32'hffff_ffff);
    chk("clear all", 32'h0, mask);
    acc(1'b1, 8'h18, 4'hf, 32'hffff_ffff);
    chk("unmapped write", 32'h0, mask);
    acc(1'b0, 8'h18, 4'hf, 32'h0);
    chk("unmapped read", 32'h0, got);
    acc(1'b1, UIE_OFS_MASK_SET, 4'h1, 32'hffff_ffff);
    chk("low lane write", 32'h0000_007f, mask);
    @(posedge clk_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    #1;
    chk("mask after soft reset", UIE_MASK_RESET, mask);
    stop_test();
  end

  initial begin
    #100us;
    n_fail++;
    stop_test();
  end
endmodule
